// >>> shared/ast_pkg.sv
package ast_pkg;

   // --------------------------------------------------------------
   // register map
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_BAUD_DIV = 8'h09;
   localparam logic [7:0] ADDR_UART_CONTROL = 8'h0A;
   localparam logic [7:0] ADDR_UART_STATUS = 8'h0B;
   localparam logic [7:0] ADDR_UART_DATA = 8'h0C;

   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [7:0] STATUS_RST = 8'h20;
   localparam logic [7:0] CONTROL_RST = 8'h02;
   localparam logic [7:0] BAUD_DIV_RST = 8'h00;

   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int ST_RX_DONE = 7;
   localparam int ST_TX_DONE = 6;
   localparam int ST_TX_EMPTY = 5;
   localparam int ST_FRAME_ERR = 4;
   localparam int ST_OVERRUN = 3;
   localparam int CT_RX_IRQ_EN = 7;
   localparam int CT_TXD_IRQ_EN = 6;
   localparam int CT_TXE_IRQ_EN = 5;
   localparam int CT_RX_EN = 4;
   localparam int CT_TX_EN = 3;
   localparam int CT_NINE_BIT = 2;
   localparam int CT_RX_NINTH = 1;
   localparam int CT_TX_NINTH = 0;

   // --------------------------------------------------------------
   // sample points in 16x sample ticks, frame lengths in bits, last data bit indices
   // --------------------------------------------------------------
   localparam logic [3:0] SMP_FIRST = 4'h1;
   localparam logic [3:0] SMP_VOTE_A = 4'h8;
   localparam logic [3:0] SMP_VOTE_B = 4'h9;
   localparam logic [3:0] SMP_VOTE_C = 4'hA;
   localparam logic [3:0] SMP_BIT_END = 4'hF;
   localparam logic [3:0] TX_FRAME_8 = 4'hA;
   localparam logic [3:0] TX_FRAME_9 = 4'hB;
   localparam logic [3:0] RX_LAST_8 = 4'h7;
   localparam logic [3:0] RX_LAST_9 = 4'h8;

   // --------------------------------------------------------------
   // types
   // --------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ast_bus_req_t;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;

endpackage

// >>> hdl/ast_uart.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
module ast_uart
   import ast_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire ast_bus_req_t i_bus,
   input wire logic i_tx_done_ack,
   input wire logic i_rxd,
   output logic [7:0] o_rd_data,
   output logic o_txd,
   output logic o_txd_oe,
   output logic o_rx_pin_sel,
   output logic o_irq_rx,
   output logic o_irq_tx_done,
   output logic o_irq_tx_empty
);

   // --------------------------------------------------------------
   // register access decode
   // --------------------------------------------------------------
   logic wr_baud;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_data;
   logic rd_data;

   assign wr_baud = i_bus.wr && (i_bus.addr == ADDR_BAUD_DIV);
   assign wr_ctrl = i_bus.wr && (i_bus.addr == ADDR_UART_CONTROL);
   assign wr_stat = i_bus.wr && (i_bus.addr == ADDR_UART_STATUS);
   assign wr_data = i_bus.wr && (i_bus.addr == ADDR_UART_DATA);
   assign rd_data = i_bus.rd && (i_bus.addr == ADDR_UART_DATA);

   logic [7:0] baud_div_r;
   logic rx_irq_en_r;
   logic txd_irq_en_r;
   logic txe_irq_en_r;
   logic rx_en_r;
   logic tx_en_r;
   logic nine_bit_r;
   logic tx_ninth_r;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         baud_div_r <= BAUD_DIV_RST;
      end
      else if (wr_baud)
      begin
         baud_div_r <= i_bus.wdata;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         rx_irq_en_r <= CONTROL_RST[CT_RX_IRQ_EN];
         txd_irq_en_r <= CONTROL_RST[CT_TXD_IRQ_EN];
         txe_irq_en_r <= CONTROL_RST[CT_TXE_IRQ_EN];
         rx_en_r <= CONTROL_RST[CT_RX_EN];
         tx_en_r <= CONTROL_RST[CT_TX_EN];
         nine_bit_r <= CONTROL_RST[CT_NINE_BIT];
         tx_ninth_r <= CONTROL_RST[CT_TX_NINTH];
      end
      else if (wr_ctrl)
      begin
         rx_irq_en_r <= i_bus.wdata[CT_RX_IRQ_EN];
         txd_irq_en_r <= i_bus.wdata[CT_TXD_IRQ_EN];
         txe_irq_en_r <= i_bus.wdata[CT_TXE_IRQ_EN];
         rx_en_r <= i_bus.wdata[CT_RX_EN];
         tx_en_r <= i_bus.wdata[CT_TX_EN];
         nine_bit_r <= i_bus.wdata[CT_NINE_BIT];
         tx_ninth_r <= i_bus.wdata[CT_TX_NINTH];
      end
   end

   // --------------------------------------------------------------
   // baud prescaler
   // --------------------------------------------------------------
   logic [7:0] pre_cnt_r;
   logic tick16;

   assign tick16 = (pre_cnt_r == baud_div_r);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || tick16)
      begin
         pre_cnt_r <= 8'h00;
      end
      else
      begin
         pre_cnt_r <= pre_cnt_r + 8'h01;
      end
   end

   // --------------------------------------------------------------
   // transmitter
   // --------------------------------------------------------------
   logic [3:0] tx_sub_r;
   logic [10:0] tx_sh_r;
   logic [3:0] tx_left_r;
   logic tx_busy_r;
   logic [7:0] tx_hold_r;
   logic hold_full_r;
   logic tx_done_r;
   logic bit_tick;
   logic tx_end;
   logic tx_load;
   logic tx_done_clr;

   // free-running sub-bit phase; a load waits up to one bit time for it
   assign bit_tick = tick16 && (tx_sub_r == SMP_BIT_END);
   assign tx_end = tx_busy_r && bit_tick && (tx_left_r == 4'h0);
   // a busy shifter keeps the path alive after the enable drops
   assign tx_load = hold_full_r && (tx_en_r || tx_busy_r) && (!tx_busy_r || tx_end);
   assign tx_done_clr = i_tx_done_ack || (wr_stat && i_bus.wdata[ST_TX_DONE]);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         tx_sub_r <= 4'h0;
      end
      else if (tick16)
      begin
         tx_sub_r <= tx_sub_r + 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         tx_hold_r <= 8'h00;
      end
      else if (wr_data)
      begin
         tx_hold_r <= i_bus.wdata;
      end
   end

   // a write in the load cycle refills the holder, so it stays full
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         hold_full_r <= ~STATUS_RST[ST_TX_EMPTY];
      end
      else if (wr_data)
      begin
         hold_full_r <= 1'b1;
      end
      else if (tx_load)
      begin
         hold_full_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         tx_sh_r <= 11'h7FF;
         tx_left_r <= 4'h0;
         tx_busy_r <= 1'b0;
         o_txd <= 1'b1;
      end
      else if (tx_load)
      begin
         tx_busy_r <= 1'b1;
         if (nine_bit_r)
         begin
            tx_sh_r <= {1'b1, tx_ninth_r, tx_hold_r, 1'b0};
            tx_left_r <= TX_FRAME_9;
         end
         else
         begin
            tx_sh_r <= {2'b11, tx_hold_r, 1'b0};
            tx_left_r <= TX_FRAME_8;
         end
      end
      else if (tx_end)
      begin
         tx_busy_r <= 1'b0;
      end
      else if (tx_busy_r && bit_tick)
      begin
         o_txd <= tx_sh_r[0];
         tx_sh_r <= {1'b1, tx_sh_r[10:1]};
         tx_left_r <= tx_left_r - 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         tx_done_r <= STATUS_RST[ST_TX_DONE];
      end
      else if (tx_end && !hold_full_r && !wr_data)
      begin
         tx_done_r <= 1'b1;
      end
      else if (tx_done_clr)
      begin
         tx_done_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_txd_oe <= 1'b0;
      end
      else
      begin
         o_txd_oe <= tx_en_r || tx_busy_r;
      end
   end

   // --------------------------------------------------------------
   // receiver
   // --------------------------------------------------------------
   ast_rx_state_t rx_st_r;
   logic [3:0] rx_smp_r;
   logic [1:0] votes_r;
   logic [3:0] rx_cnt_r;
   logic [8:0] rx_sh_r;
   logic [7:0] rx_data_r;
   logic rx_ninth_r;
   logic rx_done_r;
   logic frame_err_r;
   logic overrun_r;
   logic ovr_pend_r;
   logic maj;
   logic decide;
   logic rx_finish;
   logic rx_xfer;
   logic rx_lost;

   assign maj = (votes_r[0] & votes_r[1]) | (votes_r[0] & i_rxd) | (votes_r[1] & i_rxd);
   assign decide = tick16 && (rx_smp_r == SMP_VOTE_C) && (rx_st_r != RX_IDLE);
   assign rx_finish = rx_en_r && decide && (rx_st_r == RX_STOP);
   // a read in the same cycle frees the data register in time
   assign rx_xfer = rx_finish && (!rx_done_r || rd_data);
   assign rx_lost = rx_finish && !rx_xfer;

   // sample index 1..15 then 0 for sample 16, continuous across bits
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || (rx_st_r == RX_IDLE))
      begin
         // the start sample itself was sample 1, so the next tick must read 2
         rx_smp_r <= SMP_FIRST + 4'h1;
      end
      else if (tick16)
      begin
         rx_smp_r <= rx_smp_r + 4'h1;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         votes_r <= 2'b11;
      end
      else if (tick16 && (rx_smp_r == SMP_VOTE_A))
      begin
         votes_r[0] <= i_rxd;
      end
      else if (tick16 && (rx_smp_r == SMP_VOTE_B))
      begin
         votes_r[1] <= i_rxd;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || !rx_en_r)
      begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= 4'h0;
      end
      else if (tick16)
      begin
         case (rx_st_r)
            RX_IDLE:
            begin
               if (!i_rxd)
               begin
                  rx_st_r <= RX_START;
               end
            end
            RX_START:
            begin
               if (decide)
               begin
                  rx_st_r <= maj ? RX_IDLE : RX_DATA;
                  rx_cnt_r <= 4'h0;
               end
            end
            RX_DATA:
            begin
               if (decide)
               begin
                  if (rx_cnt_r == (nine_bit_r ? RX_LAST_9 : RX_LAST_8))
                  begin
                     rx_st_r <= RX_STOP;
                  end
                  rx_cnt_r <= rx_cnt_r + 4'h1;
               end
            end
            RX_STOP:
            begin
               if (decide)
               begin
                  rx_st_r <= RX_IDLE;
               end
            end
            default:
            begin
               rx_st_r <= RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         rx_sh_r <= 9'h000;
      end
      else if (decide && (rx_st_r == RX_DATA))
      begin
         rx_sh_r <= {maj, rx_sh_r[8:1]};
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         rx_data_r <= 8'h00;
         rx_ninth_r <= CONTROL_RST[CT_RX_NINTH];
         frame_err_r <= STATUS_RST[ST_FRAME_ERR];
      end
      else if (rx_xfer)
      begin
         rx_data_r <= nine_bit_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
         frame_err_r <= !maj;
         if (nine_bit_r)
         begin
            rx_ninth_r <= rx_sh_r[8];
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         rx_done_r <= STATUS_RST[ST_RX_DONE];
      end
      else if (rx_xfer)
      begin
         rx_done_r <= 1'b1;
      end
      else if (rd_data)
      begin
         rx_done_r <= 1'b0;
      end
   end

   // the loss is kept aside until the held byte is read
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         ovr_pend_r <= 1'b0;
      end
      else if (rx_lost)
      begin
         ovr_pend_r <= 1'b1;
      end
      else if (rd_data)
      begin
         ovr_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         overrun_r <= STATUS_RST[ST_OVERRUN];
      end
      else if (rd_data && ovr_pend_r)
      begin
         overrun_r <= 1'b1;
      end
      else if (rx_xfer)
      begin
         overrun_r <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_rx_pin_sel <= 1'b0;
      end
      else
      begin
         o_rx_pin_sel <= rx_en_r;
      end
   end

   // --------------------------------------------------------------
   // read port and interrupt requests
   // --------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b || !i_bus.rd)
      begin
         o_rd_data <= 8'h00;
      end
      else
      begin
         case (i_bus.addr)
            ADDR_BAUD_DIV: o_rd_data <= baud_div_r;
            ADDR_UART_CONTROL: o_rd_data <= {rx_irq_en_r, txd_irq_en_r, txe_irq_en_r,
                                          rx_en_r, tx_en_r, nine_bit_r, rx_ninth_r, 1'b0};
            ADDR_UART_STATUS: o_rd_data <= {rx_done_r, tx_done_r, ~hold_full_r,
                                         frame_err_r, overrun_r, 3'b000};
            ADDR_UART_DATA: o_rd_data <= rx_data_r;
            default: o_rd_data <= 8'h00;
         endcase
      end
   end

   // requests lag their flags by one clock so they leave from flops
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         o_irq_rx <= 1'b0;
         o_irq_tx_done <= 1'b0;
         o_irq_tx_empty <= 1'b0;
      end
      else
      begin
         o_irq_rx <= rx_done_r && rx_irq_en_r;
         o_irq_tx_done <= tx_done_r && txd_irq_en_r;
         o_irq_tx_empty <= !hold_full_r && txe_irq_en_r;
      end
   end

endmodule

// >>> tb/ast_uart_chk.sv
`timescale 1ns/10ps
module ast_uart_chk
   import ast_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire ast_bus_req_t i_bus,
   input wire logic i_tx_done_ack,
   input wire logic i_rxd,
   input wire logic [7:0] o_rd_data,
   input wire logic o_txd,
   input wire logic o_txd_oe,
   input wire logic o_rx_pin_sel,
   input wire logic o_irq_rx,
   input wire logic o_irq_tx_done,
   input wire logic o_irq_tx_empty
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_b);
   // ----
   // line history
   // ----
   logic [7:0] div_r;
   logic txd_q_r;
   int run_r;
   logic wr_ctl;
   logic rd_dat;
   assign wr_ctl = i_bus.wr && i_bus.addr == ADDR_UART_CONTROL;
   assign rd_dat = i_bus.rd && i_bus.addr == ADDR_UART_DATA;
   // divisor shadow so the bit length follows software changes made while idle
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         div_r <= BAUD_DIV_RST;
         txd_q_r <= 1'b1;
         run_r <= 0;
      end
      else
      begin
         if (i_bus.wr && i_bus.addr == ADDR_BAUD_DIV)
            div_r <= i_bus.wdata;
         txd_q_r <= o_txd;
         run_r <= (o_txd != txd_q_r) ? 1 : run_r + 1;
      end
   end
   // ----
   // properties
   // ----
   chk_rd_idle_zero: assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00)
      else $error("read data outside answer");
   chk_status_low_zero: assert property ($past(i_bus.rd) &&
      $past(i_bus.addr) == ADDR_UART_STATUS |-> o_rd_data[2:0] == 3'h0)
      else $error("status low bits set");
   chk_bit_length: assert property (!txd_q_r && o_txd |->
      run_r % (16 * (int'(div_r) + 1)) == 0)
      else $error("low run not whole bits");
   chk_oe_on_enable: assert property (wr_ctl && i_bus.wdata[CT_TX_EN] |-> ##[1:2] o_txd_oe)
      else $error("enable did not take pin");
   chk_rx_pin_sel: assert property (wr_ctl |=> ##1 o_rx_pin_sel ==
      $past(i_bus.wdata[CT_RX_EN], 2))
      else $error("rx pin select wrong");
   chk_txd_idle_high: assert property (!o_txd_oe |-> o_txd)
      else $error("line low while released");
   chk_done_line_high: assert property ($rose(o_irq_tx_done) |-> o_txd)
      else $error("tx done during frame");
   chk_tx_ack_clear: assert property (i_tx_done_ack |-> ##2 !o_irq_tx_done)
      else $error("ack did not clear");
   chk_rx_irq_clear: assert property (rd_dat |-> ##[1:3] !o_irq_rx)
      else $error("read did not clear");
   cover property ($rose(o_irq_rx));
   cover property (i_tx_done_ack && o_irq_tx_done);
   cover property (!txd_q_r && o_txd && o_txd_oe);
endmodule

bind ast_uart ast_uart_chk u_chk (
   .i_clk, .i_rst_b, .i_bus, .i_tx_done_ack, .i_rxd, .o_rd_data, .o_txd, .o_txd_oe,
   .o_rx_pin_sel, .o_irq_rx, .o_irq_tx_done, .o_irq_tx_empty
);

// >>> tb/ast_peer.sv
`timescale 1ns/10ps
module ast_peer (
   input wire logic i_clk,
   input wire logic i_txd,
   output logic o_rxd
);
   // clocks per bit, kept equal to 16 times (divisor plus one) by the bench
   int bitc = 16;
   initial
   begin
      o_rxd = 1'b1;
   end
   task automatic send(input logic [8:0] d, input logic nine, input logic stop);
      o_rxd <= 1'b0;
      repeat (bitc) @(posedge i_clk);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
         o_rxd <= d[i];
         repeat (bitc) @(posedge i_clk);
      end
      o_rxd <= stop;
      repeat (bitc) @(posedge i_clk);
      o_rxd <= 1'b1;
   endtask
   // short low pulse, then a bit of idle so the next start is clean
   task automatic glitch(input int n);
      o_rxd <= 1'b0;
      repeat (n) @(posedge i_clk);
      o_rxd <= 1'b1;
      repeat (bitc) @(posedge i_clk);
   endtask
   task automatic recv(input logic nine, output logic [8:0] d, output logic stop,
      output logic ok);
      int n;
      n = 0;
      d = 9'h000;
      while (i_txd !== 1'b0 && n < 20000)
      begin
         @(posedge i_clk);
         n++;
      end
      ok = n < 20000;
      repeat (bitc / 2) @(posedge i_clk);
      for (int i = 0; i < (nine ? 9 : 8); i++)
      begin
         repeat (bitc) @(posedge i_clk);
         d[i] = i_txd;
      end
      repeat (bitc) @(posedge i_clk);
      stop = i_txd;
   endtask
endmodule

// >>> tb/ast_uart_tb_top.sv
`timescale 1ns/10ps
module ast_uart_tb_top
   import ast_pkg::*;
();
   ast_bus_req_t bus;
   logic clk, rst_b, ack, rxd, txd, txd_oe, rx_sel, irq_rx, irq_txd, irq_txe, stp, ok;
   logic [7:0] rd_data;
   logic [8:0] got;
   logic [8:0] nine_v [2] = '{9'h03C, 9'h1C3};
   int n_errors = 0;
   int num_checks = 0;
   ast_uart u_dut (
      .i_clk(clk), .i_rst_b(rst_b), .i_bus(bus), .i_tx_done_ack(ack), .i_rxd(rxd),
      .o_rd_data(rd_data), .o_txd(txd), .o_txd_oe(txd_oe), .o_rx_pin_sel(rx_sel),
      .o_irq_rx(irq_rx), .o_irq_tx_done(irq_txd), .o_irq_tx_empty(irq_txe)
   );
   ast_peer u_peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ----
   // access tasks
   // ----
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      check({1'b0, rd_data}, {1'b0, e});
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      n_errors++;
      complete_run();
   end
   // ----
   // main sequence
   // ----
   initial
   begin
      bus = '0;
      ack = 1'b0;
      rst_b = 1'b0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      rchk(ADDR_UART_STATUS, STATUS_RST);
      rchk(ADDR_UART_CONTROL, CONTROL_RST);
      rchk(8'h0F, 8'h00);
      check(9'(txd_oe), 9'h000);
      $display("test reset done");
      wr(ADDR_UART_CONTROL, 8'h68);
      settle(2);
      check(9'(txd_oe), 9'h001);
      check(9'(irq_txe), 9'h001);
      fork
         begin
            u_peer.recv(1'b0, got, stp, ok);
            check(got, 9'h0A5);
            check(9'(ok), 9'h001);
            check(9'(stp), 9'h001);
            u_peer.recv(1'b0, got, stp, ok);
            check(got, 9'h03C);
            check(9'(ok), 9'h001);
            rchk(ADDR_UART_STATUS, 8'h20);
         end
         begin
            wr(ADDR_UART_DATA, 8'hA5);
            rchk(ADDR_UART_STATUS, 8'h20);
            wr(ADDR_UART_DATA, 8'h3C);
            rchk(ADDR_UART_STATUS, 8'h00);
            check(9'(irq_txe), 9'h000);
         end
      join
      settle(40);
      rchk(ADDR_UART_STATUS, 8'h60);
      check(9'(irq_txd), 9'h001);
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      rchk(ADDR_UART_STATUS, 8'h20);
      $display("test transmit done");
      // slower divisor from here on, the peer follows it
      wr(ADDR_BAUD_DIV, 8'h01);
      rchk(ADDR_BAUD_DIV, 8'h01);
      u_peer.bitc = 32;
      wr(ADDR_UART_CONTROL, 8'h0D);
      fork
         u_peer.recv(1'b1, got, stp, ok);
         begin
            wr(ADDR_UART_DATA, 8'h5A);
            wr(ADDR_UART_CONTROL, 8'h04);
         end
      join
      settle(1);
      check(got, 9'h15A);
      check(9'(ok), 9'h001);
      check(9'(txd_oe), 9'h001);
      settle(80);
      check(9'(txd_oe), 9'h000);
      rchk(ADDR_UART_STATUS, 8'h60);
      wr(ADDR_UART_STATUS, 8'h40);
      rchk(ADDR_UART_STATUS, 8'h20);
      $display("test nine bit transmit done");
      wr(ADDR_UART_CONTROL, 8'h90);
      settle(2);
      check(9'(rx_sel), 9'h001);
      u_peer.glitch(12);
      u_peer.send(9'h096, 1'b0, 1'b1);
      settle(2);
      check(9'(irq_rx), 9'h001);
      rchk(ADDR_UART_STATUS, 8'hA0);
      rchk(ADDR_UART_DATA, 8'h96);
      rchk(ADDR_UART_STATUS, 8'h20);
      u_peer.send(9'h011, 1'b0, 1'b0);
      settle(40);
      rchk(ADDR_UART_STATUS, 8'hB0);
      u_peer.send(9'h022, 1'b0, 1'b1);
      rchk(ADDR_UART_DATA, 8'h11);
      rchk(ADDR_UART_STATUS, 8'h38);
      u_peer.send(9'h033, 1'b0, 1'b1);
      rchk(ADDR_UART_STATUS, 8'hA0);
      rchk(ADDR_UART_DATA, 8'h33);
      $display("test receive done");
      wr(ADDR_UART_CONTROL, 8'h14);
      foreach (nine_v[i])
      begin
         u_peer.send(nine_v[i], 1'b1, 1'b1);
         rchk(ADDR_UART_CONTROL, {6'h05, nine_v[i][8], 1'b0});
         rchk(ADDR_UART_DATA, nine_v[i][7:0]);
      end
      wr(ADDR_UART_CONTROL, 8'h10);
      u_peer.send(9'h055, 1'b0, 1'b1);
      wr(ADDR_UART_CONTROL, 8'h00);
      settle(2);
      check(9'(rx_sel), 9'h000);
      rchk(ADDR_UART_STATUS, 8'hA0);
      rchk(ADDR_UART_DATA, 8'h55);
      u_peer.send(9'h066, 1'b0, 1'b1);
      rchk(ADDR_UART_STATUS, 8'h20);
      $display("test receiver off done");
      complete_run();
   end
endmodule
